// [rtl/cfg_pkg.sv]
// Package: register map, field layout, reset values and carriers
package cfg_pkg;
  // How it works
  // RL1: One drive-style bit per interrupt line 3..7, at register bits 3..7.
  // RL2: Style 0 drives the line active high, high impedance when not driven.
  // RL3: Style 1 pulls the line low, open collector, so it can be shared.
  // RL4: Interrupt drive-style bits reset to 0; low three bits are reserved.
  // RL5: Drive count 0 gives two drives, selected directly without a decoder.
  // RL6: Drive count 1 gives encoded selects for an external four-drive decoder.
  // RL7: Four-drive operation forces the drive powerdown enable off.
  // RL8: Drive count resets from straps in extended hardware mode, else two drives.
  // RL9: Address select 0 decodes the floppy controller at ports 3F0-3F7.
  // RL10: Address select 1 decodes the floppy controller at ports 370-377.
  // RL11: Address select resets to 0 in software modes, from straps in hardware modes.
  // RL12: The floppy controller runs only while its enable bit is 1.
  // RL13: Enable resets to 1 in software modes, from straps in hardware modes.
  // RL14: Disabled controller leaves interrupt line 6 and its DMA request floating.
  // RL15: Every floppy configuration bit is writable and reads back its value.
  // RL16: Floppy configuration resets to count 0, address 0, enable 1; bits 6:2 reserved.
  // RL17: Mode field: 00 sw motherboard, 01 sw add-in, 10 ext hw, 11 basic hw.
  // RL18: Host writes an index port, then uses the target port; straps pick the pair.
  // RL19: Reserved bits read as zero and ignore writes.

  // Register indexes
  localparam logic [7:0] IDX_IRQ_MODE  = 8'h03;
  localparam logic [7:0] IDX_FDC_CFG   = 8'h10;
  // Field positions
  localparam int         IRQ_STYLE_LSB = 3;
  localparam int         QTY_BIT       = 7;
  localparam int         ADS_BIT       = 1;
  localparam int         EN_BIT        = 0;
  // Reset values for the software modes
  localparam logic [4:0] IRQ_STYLE_RST = 5'h00;
  localparam logic       QTY_RST       = 1'h0;
  localparam logic       ADS_RST       = 1'h0;
  localparam logic       EN_RST        = 1'h1;
  // Index and target ports, primary and secondary pair
  localparam logic [9:0] IDX_PORT_PRI  = 10'h022;
  localparam logic [9:0] TGT_PORT_PRI  = 10'h023;
  localparam logic [9:0] IDX_PORT_SEC  = 10'h024;
  localparam logic [9:0] TGT_PORT_SEC  = 10'h025;
  // Floppy controller port ranges, eight ports each
  localparam logic [9:0] FDC_BASE_PRI  = 10'h3f0;
  localparam logic [9:0] FDC_BASE_SEC  = 10'h370;
  // Cycles after reset release until the synchronised straps are valid
  localparam logic [1:0] STRAP_WAIT    = 2'h2;

  typedef enum logic [1:0] {
    MODE_SW_MOTHERBOARD = 2'b00,
    MODE_SW_ADDIN       = 2'b01,
    MODE_HW_EXTENDED    = 2'b10,
    MODE_HW_BASIC       = 2'b11
  } cfg_mode_t;

  // ISA pins seen by the block
  typedef struct packed {
    logic       aen;
    logic       ior_n;
    logic       iow_n;
    logic [9:0] addr;
    logic [7:0] data;
  } isa_in_t;

  // Strap pins
  typedef struct packed {
    cfg_mode_t configuration_mode_field;
    logic      port_secondary;
    logic      drive_count_select;
    logic      controller_address_select;
    logic      controller_enable;
  } strap_t;

  // State of the configuration block
  typedef struct packed {
    logic [1:0] strap_cnt;
    logic       loaded;
    cfg_mode_t  mode;
    logic [7:0] index;
    logic [4:0] irq_style;
    logic       drive_count_select;
    logic       controller_address_select;
    logic       controller_enable;
    logic       iow_n_prev;
    logic       wr_ok;
    logic [9:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic       rd_oe;
    logic       fdc_cs;
    logic [1:0] ds_n;
    logic       dec_en_n;
  } ctrl_state_t;
endpackage

// [rtl/pin_sync.sv]
// Two-flip-flop synchroniser for a vector of pins
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t st_ff;
  sync_t nxt_st;

  // First stage feeds only the second
  always_comb begin
    nxt_st.s1 = pin_i;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_o = st_ff.s2;
endmodule

// [rtl/irq_pin_drive.sv]
// Pin drivers for interrupt lines 3..7 and the floppy DMA request
module irq_pin_drive #(
  parameter int LINES = 5,
  parameter int FDC_LINE = 3
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [LINES-1:0] style_i,
  input  wire logic [LINES-1:0] req_i,
  input  wire logic [LINES-1:0] line_en_i,
  input  wire logic             fdc_en_i,
  input  wire logic             drq_i,
  output logic      [LINES-1:0] irq_o,
  output logic      [LINES-1:0] irq_oe_n_o,
  output logic                  drq_o,
  output logic                  drq_oe_n_o
);
  typedef struct packed {
    logic [LINES-1:0] out;
    logic [LINES-1:0] oe_n;
    logic             drq;
    logic             drq_oe_n;
  } drive_t;

  drive_t st_ff;
  drive_t nxt_st;
  logic   live;

  // Per-line drive style, floppy line gated by the enable
  always_comb begin
    nxt_st = st_ff;
    live   = 1'b0;
    for (int i = 0; i < LINES; i++) begin
      live = line_en_i[i] && (i != FDC_LINE || fdc_en_i); // RL14
      if (!style_i[i]) begin
        nxt_st.out[i]  = req_i[i];                        // RL2
        nxt_st.oe_n[i] = !live;                           // RL2
      end else begin
        nxt_st.out[i]  = 1'b0;                            // RL3
        nxt_st.oe_n[i] = !(live && req_i[i]);             // RL3
      end
    end
    nxt_st.drq      = drq_i;
    nxt_st.drq_oe_n = !fdc_en_i;                          // RL14
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '{out: '0, oe_n: '1, drq: 1'b0, drq_oe_n: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign irq_o      = st_ff.out;
  assign irq_oe_n_o = st_ff.oe_n;
  assign drq_o      = st_ff.drq;
  assign drq_oe_n_o = st_ff.drq_oe_n;
endmodule

// [rtl/irq_fdc_cfg.sv]
// Interrupt drive style and floppy controller configuration registers
module irq_fdc_cfg (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // ISA pins
  input  wire logic [9:0] sa_i,
  input  wire logic [7:0] sd_i,
  input  wire logic       ior_n_i,
  input  wire logic       iow_n_i,
  input  wire logic       aen_i,
  output logic      [7:0] sd_o,
  output logic            sd_oe_n_o,
  // Strap pins
  input  wire logic [1:0] mode_strap_i,
  input  wire logic       port_strap_i,
  input  wire logic       qty_strap_i,
  input  wire logic       ads_strap_i,
  input  wire logic       en_strap_i,
  // Interrupt sources for lines 3..7
  input  wire logic [4:0] irq_req_i,
  input  wire logic [4:0] irq_line_en_i,
  output logic      [4:0] irq_o,
  output logic      [4:0] irq_oe_n_o,
  // Floppy controller side
  input  wire logic       fdc_drq_i,
  output logic            floppy_dma_request_o,
  output logic            floppy_dma_request_oe_n_o,
  input  wire logic [1:0] drive_num_i,
  input  wire logic       drive_active_i,
  output logic      [1:0] drive_sel_n_o,
  output logic            drive_decoder_en_n_o,
  input  wire logic       drive_powerdown_enable_i,
  output logic            drive_powerdown_enable_o,
  output logic            fdc_cs_o,
  output logic            controller_enable_o,
  output logic            drive_count_select_o,
  output logic            controller_address_select_o,
  output logic      [1:0] configuration_mode_field_o
);
  cfg_pkg::ctrl_state_t st_ff;
  cfg_pkg::ctrl_state_t nxt_st;
  cfg_pkg::isa_in_t     bus;
  cfg_pkg::strap_t      strap;
  logic [9:0]           fdc_base;
  logic                 rd_hit;
  logic                 wr_done;

  // Index or target port match for the strapped pair
  function automatic logic port_is(input logic [9:0] addr, input logic sec,
                                   input logic target);
    logic [9:0] want;
    if (target) begin
      want = sec ? cfg_pkg::TGT_PORT_SEC : cfg_pkg::TGT_PORT_PRI;
    end else begin
      want = sec ? cfg_pkg::IDX_PORT_SEC : cfg_pkg::IDX_PORT_PRI;
    end
    return addr == want;
  endfunction

  // Readback of a mapped index, reserved bits as zero
  function automatic logic [7:0] reg_value(input cfg_pkg::ctrl_state_t s);
    logic [7:0] v;
    v = 8'h00;
    if (s.index == cfg_pkg::IDX_IRQ_MODE) begin
      v[cfg_pkg::IRQ_STYLE_LSB +: 5] = s.irq_style;              // RL19
    end else if (s.index == cfg_pkg::IDX_FDC_CFG) begin
      v[cfg_pkg::QTY_BIT] = s.drive_count_select;                // RL15
      v[cfg_pkg::ADS_BIT] = s.controller_address_select;         // RL15
      v[cfg_pkg::EN_BIT]  = s.controller_enable;                 // RL15
    end
    return v;
  endfunction

  // Bus pins pass two flip-flops
  pin_sync #(
    .W ($bits(cfg_pkg::isa_in_t))
  ) u_bus_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     ({aen_i, ior_n_i, iow_n_i, sa_i, sd_i}),
    .sync_o    (bus)
  );

  // Straps pass two flip-flops as well
  pin_sync #(
    .W ($bits(cfg_pkg::strap_t))
  ) u_strap_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     ({mode_strap_i, port_strap_i, qty_strap_i, ads_strap_i, en_strap_i}),
    .sync_o    (strap)
  );

  // Base of the floppy controller range
  assign fdc_base = st_ff.controller_address_select ? cfg_pkg::FDC_BASE_SEC
                                                    : cfg_pkg::FDC_BASE_PRI; // RL9 RL10

  // Read hit on the index port or a mapped target
  assign rd_hit = st_ff.loaded && !bus.aen && !bus.ior_n &&
                  (port_is(bus.addr, strap.port_secondary, 1'b0) ||
                   (port_is(bus.addr, strap.port_secondary, 1'b1) &&
                    (st_ff.index == cfg_pkg::IDX_IRQ_MODE ||
                     st_ff.index == cfg_pkg::IDX_FDC_CFG)));  // RL18

  // End of a write cycle seen on the synchronised strobe
  assign wr_done = bus.iow_n && !st_ff.iow_n_prev && st_ff.wr_ok && st_ff.loaded;

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    // Strap capture once the synchronisers hold valid levels
    if (!st_ff.loaded) begin
      nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
      if (st_ff.strap_cnt == cfg_pkg::STRAP_WAIT) begin
        nxt_st.loaded = 1'b1;
        nxt_st.mode   = strap.configuration_mode_field;          // RL17
        if (strap.configuration_mode_field == cfg_pkg::MODE_HW_EXTENDED) begin
          nxt_st.drive_count_select = strap.drive_count_select;  // RL8
        end
        if (strap.configuration_mode_field[1]) begin
          nxt_st.controller_address_select = strap.controller_address_select; // RL11
          nxt_st.controller_enable         = strap.controller_enable;         // RL13
        end
      end
    end
    // Hold address and data while the write strobe is low
    nxt_st.iow_n_prev = bus.iow_n;
    if (!bus.iow_n) begin
      nxt_st.wr_addr = bus.addr;
      nxt_st.wr_data = bus.data;
      nxt_st.wr_ok   = !bus.aen;
    end
    // Commit at the trailing edge of the write
    if (wr_done) begin
      nxt_st.wr_ok = 1'b0;
      if (port_is(st_ff.wr_addr, strap.port_secondary, 1'b0)) begin
        nxt_st.index = st_ff.wr_data;                            // RL18
      end else if (port_is(st_ff.wr_addr, strap.port_secondary, 1'b1)) begin
        if (st_ff.index == cfg_pkg::IDX_IRQ_MODE) begin
          nxt_st.irq_style = st_ff.wr_data[cfg_pkg::IRQ_STYLE_LSB +: 5]; // RL1
        end else if (st_ff.index == cfg_pkg::IDX_FDC_CFG) begin
          nxt_st.drive_count_select        = st_ff.wr_data[cfg_pkg::QTY_BIT]; // RL15
          nxt_st.controller_address_select = st_ff.wr_data[cfg_pkg::ADS_BIT]; // RL15
          nxt_st.controller_enable         = st_ff.wr_data[cfg_pkg::EN_BIT];  // RL15
        end
      end
    end
    // Read data and bus drive
    nxt_st.rd_oe   = rd_hit;
    nxt_st.rd_data = 8'h00;
    if (rd_hit) begin
      nxt_st.rd_data = port_is(bus.addr, strap.port_secondary, 1'b0) ? st_ff.index
                                                                     : reg_value(st_ff);
    end
    // Floppy controller chip select
    nxt_st.fdc_cs = st_ff.controller_enable && !bus.aen &&
                    (!bus.ior_n || !bus.iow_n) &&
                    bus.addr[9:3] == fdc_base[9:3];              // RL9 RL10 RL12
    // Drive selects: direct for two drives, encoded for four
    if (!st_ff.drive_count_select) begin
      nxt_st.ds_n[0]  = !(drive_active_i && drive_num_i == 2'h0); // RL5
      nxt_st.ds_n[1]  = !(drive_active_i && drive_num_i == 2'h1); // RL5
      nxt_st.dec_en_n = 1'b1;                                     // RL5
    end else begin
      nxt_st.ds_n     = drive_num_i;                              // RL6
      nxt_st.dec_en_n = !drive_active_i;                          // RL6
    end
  end

  // State register with software-mode defaults
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '{
        strap_cnt:                 2'h0,
        loaded:                    1'b0,
        mode:                      cfg_pkg::MODE_SW_MOTHERBOARD,
        index:                     8'h00,
        irq_style:                 cfg_pkg::IRQ_STYLE_RST,       // RL4
        drive_count_select:        cfg_pkg::QTY_RST,             // RL16
        controller_address_select: cfg_pkg::ADS_RST,             // RL16
        controller_enable:         cfg_pkg::EN_RST,              // RL16
        iow_n_prev:                1'b1,
        wr_ok:                     1'b0,
        wr_addr:                   10'h000,
        wr_data:                   8'h00,
        rd_data:                   8'h00,
        rd_oe:                     1'b0,
        fdc_cs:                    1'b0,
        ds_n:                      2'h3,
        dec_en_n:                  1'b1
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Interrupt and DMA request pins
  irq_pin_drive #(
    .LINES    (5),
    .FDC_LINE (3)
  ) u_drive (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .style_i    (st_ff.irq_style),
    .req_i      (irq_req_i),
    .line_en_i  (irq_line_en_i),
    .fdc_en_i   (st_ff.controller_enable),
    .drq_i      (fdc_drq_i),
    .irq_o      (irq_o),
    .irq_oe_n_o (irq_oe_n_o),
    .drq_o      (floppy_dma_request_o),
    .drq_oe_n_o (floppy_dma_request_oe_n_o)
  );

  // Outputs
  assign sd_o                        = st_ff.rd_data;
  assign sd_oe_n_o                   = !st_ff.rd_oe;
  assign fdc_cs_o                    = st_ff.fdc_cs;
  assign drive_sel_n_o               = st_ff.ds_n;
  assign drive_decoder_en_n_o        = st_ff.dec_en_n;
  assign drive_powerdown_enable_o    = drive_powerdown_enable_i &&
                                       !st_ff.drive_count_select;   // RL7
  assign controller_enable_o         = st_ff.controller_enable;     // RL12
  assign drive_count_select_o        = st_ff.drive_count_select;
  assign controller_address_select_o = st_ff.controller_address_select;
  assign configuration_mode_field_o  = st_ff.mode;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_tgt_write(logic [7:0] idx);
    wr_done && port_is(st_ff.wr_addr, strap.port_secondary, 1'b1) && st_ff.index == idx;
  endsequence

  sequence s_load(logic hw);
    !st_ff.loaded && st_ff.strap_cnt == 2'h2 && strap.configuration_mode_field[1] == hw;
  endsequence

  a_style_reset_zero: assert property ( // RL4
    !st_ff.loaded |-> st_ff.irq_style == 5'h00 && !st_ff.drive_count_select &&
                      !st_ff.controller_address_select && st_ff.controller_enable)
    else $error("defaults wrong before strap load");

  a_style_write_lands: assert property ( // RL1
    s_tgt_write(8'h03) |=> st_ff.irq_style == $past(st_ff.wr_data[7:3]))
    else $error("interrupt style write lost");

  a_fdc_write_lands: assert property ( // RL15
    s_tgt_write(8'h10) |=> st_ff.drive_count_select == $past(st_ff.wr_data[7]) &&
                           st_ff.controller_address_select == $past(st_ff.wr_data[1]) &&
                           st_ff.controller_enable == $past(st_ff.wr_data[0]))
    else $error("floppy config write lost");

  a_reserved_read_zero: assert property ( // RL19
    st_ff.rd_oe && $past(st_ff.index) == 8'h10 &&
    !$past(port_is(bus.addr, strap.port_secondary, 1'b0)) |-> st_ff.rd_data[6:2] == 5'h00)
    else $error("reserved bits read nonzero");

  a_sw_mode_defaults: assert property ( // RL11
    s_load(1'b0) |=> !st_ff.controller_address_select && st_ff.controller_enable &&
                     !st_ff.drive_count_select)
    else $error("software mode defaults not kept");

  a_hw_strap_load: assert property ( // RL13
    s_load(1'b1) |=> st_ff.controller_enable == $past(strap.controller_enable) &&
                     st_ff.controller_address_select == $past(strap.controller_address_select))
    else $error("hardware straps not loaded");

  a_qty_basic_two: assert property ( // RL8
    s_load(1'b1) ##0 strap.configuration_mode_field == cfg_pkg::MODE_HW_BASIC
    |=> !st_ff.drive_count_select)
    else $error("basic hardware mode changed drive count");

  a_style_high_drive: assert property ( // RL2
    !st_ff.irq_style[0] && irq_line_en_i[0] && irq_req_i[0]
    |=> irq_o[0] && !irq_oe_n_o[0])
    else $error("active high line not driven");

  a_style_open_coll: assert property ( // RL3
    st_ff.irq_style[1] && irq_line_en_i[1] ##0 !irq_req_i[1] |=> irq_oe_n_o[1] ##0
    (!irq_o[1]))
    else $error("open collector line drove while idle");

  a_disabled_float: assert property ( // RL14
    !st_ff.controller_enable |=> irq_oe_n_o[3] && floppy_dma_request_oe_n_o)
    else $error("disabled controller still drives");

  a_four_no_pd: assert property ( // RL7
    st_ff.drive_count_select |-> !drive_powerdown_enable_o)
    else $error("powerdown enable passed in four-drive mode");

  a_fdc_decode: assert property ( // RL10
    st_ff.controller_enable && st_ff.controller_address_select && !bus.aen &&
    !bus.ior_n && bus.addr[9:3] == 7'h6e ##1 st_ff.controller_address_select
    |-> fdc_cs_o)
    else $error("secondary floppy range not decoded");

  a_disabled_no_cs: assert property ( // RL12
    !st_ff.controller_enable |=> !fdc_cs_o)
    else $error("disabled controller selected");

  a_primary_decode: assert property ( // RL9
    st_ff.controller_enable && !st_ff.controller_address_select && !bus.aen &&
    !bus.iow_n && bus.addr[9:3] == 7'h7e |=> fdc_cs_o)
    else $error("primary floppy range not decoded");

  a_dma_ignored: assert property ( // RL18
    bus.aen |=> sd_oe_n_o && !fdc_cs_o)
    else $error("access during dma cycle answered");

  a_other_index_kept: assert property ( // RL18
    wr_done && port_is(st_ff.wr_addr, strap.port_secondary, 1'b1) &&
    st_ff.index != cfg_pkg::IDX_IRQ_MODE && st_ff.index != cfg_pkg::IDX_FDC_CFG
    |=> $stable(st_ff.irq_style) && $stable(st_ff.controller_enable) &&
        $stable(st_ff.drive_count_select) && $stable(st_ff.controller_address_select))
    else $error("write to unmapped index changed a register");

  a_mode_held: assert property ( // RL17
    st_ff.loaded |=> $stable(st_ff.mode) && st_ff.loaded)
    else $error("mode field changed after capture");

  a_drq_passes: assert property ( // RL12
    st_ff.controller_enable |=> !floppy_dma_request_oe_n_o &&
                                floppy_dma_request_o == $past(fdc_drq_i))
    else $error("enabled controller lost its dma request");

  a_two_drive_sel: assert property ( // RL5
    !st_ff.drive_count_select && drive_active_i && drive_num_i == 2'h1
    |=> drive_sel_n_o == 2'h1 && drive_decoder_en_n_o)
    else $error("two-drive select wrong");

  a_four_drive_sel: assert property ( // RL6
    st_ff.drive_count_select && drive_active_i
    |=> drive_sel_n_o == $past(drive_num_i) && !drive_decoder_en_n_o)
    else $error("encoded drive select wrong");

  a_index_readback: assert property ( // RL18
    wr_done && port_is(st_ff.wr_addr, strap.port_secondary, 1'b0)
    |=> st_ff.index == $past(st_ff.wr_data))
    else $error("index port write lost");

  a_mode_field: assert property ( // RL17
    s_load(1'b0) or s_load(1'b1) |=> configuration_mode_field_o ==
                                     $past(strap.configuration_mode_field))
    else $error("mode field not captured");
endmodule

// [verification/isa_host.sv]
// Host model driving ISA index and target port cycles
module isa_host (
  input  wire logic       clk_i,
  input  wire logic       sd_oe_n_i,
  output logic      [9:0] sa_o,
  output logic      [7:0] sd_o,
  output logic            ior_n_o,
  output logic            iow_n_o,
  output logic            aen_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    sa_o = 10'h000;
    sd_o = 8'h00;
    ior_n_o = 1'b1;
    iow_n_o = 1'b1;
    aen_o = 1'b0;
  end

  // One strobe: hold until answered or 8 edges, then idle 7 cycles
  task automatic cyc(input logic rd, input logic [9:0] a, input logic [7:0] d,
                     output logic got);
    got = 1'b0;
    @(negedge clk_i);
    sa_o = a;
    sd_o = d;
    ior_n_o = !rd;
    iow_n_o = rd;
    for (int i = 0; i < 8 && !got; i++) begin
      @(posedge clk_i);
      got = (sd_oe_n_i === 1'b0);
    end
    @(negedge clk_i);
    ior_n_o = 1'b1;
    iow_n_o = 1'b1;
    // Released bus shows no stale value
    sd_o = ~d;
    sa_o = ~a;
    repeat (7) @(negedge clk_i);
  endtask
endmodule

// [verification/irq_drive_and_fdc_config_bench.sv]
// Bench for the interrupt style and floppy configuration block
module irq_drive_and_fdc_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0, reset_n_i = 1'b0, port = 1'b0, qty = 1'b0, ads = 1'b0;
  logic       en = 1'b0, pd_i = 1'b0, cs_seen = 1'b0, oe_d = 1'b1, g, eq, ea, ee;
  logic [1:0] mode = 2'h0, dnum = 2'h0, dsel_n, c_mode;
  logic [4:0] irq_req = 5'h00, irq_en = 5'h00, irq_o, irq_oe_n;
  logic [9:0] sa, ip, tp;
  logic [7:0] sd_i, sd_o, v, s, notes[$];
  logic       ior_n, iow_n, aen, sd_oe_n, drq_o, drq_oe_n, dec_en_n, pd_o, cs;
  logic       c_en, c_qty, c_ads, eo, en_n, drq = 1'b0, act = 1'b0;
  int         failures = 0, checks_done = 0;

  initial forever #4 clk_i = ~clk_i;

  isa_host host_u (.clk_i(clk_i), .sd_oe_n_i(sd_oe_n), .sa_o(sa), .sd_o(sd_i),
    .ior_n_o(ior_n), .iow_n_o(iow_n), .aen_o(aen));

  irq_fdc_cfg dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .sa_i(sa), .sd_i(sd_i),
    .ior_n_i(ior_n), .iow_n_i(iow_n), .aen_i(aen), .sd_o(sd_o), .sd_oe_n_o(sd_oe_n),
    .mode_strap_i(mode), .port_strap_i(port), .qty_strap_i(qty), .ads_strap_i(ads),
    .en_strap_i(en), .irq_req_i(irq_req), .irq_line_en_i(irq_en), .irq_o(irq_o),
    .irq_oe_n_o(irq_oe_n), .fdc_drq_i(drq), .floppy_dma_request_o(drq_o),
    .floppy_dma_request_oe_n_o(drq_oe_n), .drive_num_i(dnum), .drive_active_i(act),
    .drive_sel_n_o(dsel_n), .drive_decoder_en_n_o(dec_en_n),
    .drive_powerdown_enable_i(pd_i), .drive_powerdown_enable_o(pd_o), .fdc_cs_o(cs),
    .controller_enable_o(c_en), .drive_count_select_o(c_qty),
    .controller_address_select_o(c_ads), .configuration_mode_field_o(c_mode));

  // Comparison and counting
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Read answers taken against the oldest note; an unasked answer fails
  always @(posedge clk_i) begin
    oe_d <= sd_oe_n;
    if (oe_d === 1'b1 && sd_oe_n === 1'b0) begin
      if (notes.size() == 0) check(8'hff, 8'h00);
      else check(sd_o, notes.pop_front());
    end
  end

  // Sticky floppy range hit
  always @(posedge clk_i) if (cs === 1'b1) cs_seen <= 1'b1;

  // Indexed accesses
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host_u.cyc(1'b0, ip, idx, g);
    host_u.cyc(1'b0, tp, d, g);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic ok);
    host_u.cyc(1'b0, ip, idx, g);
    if (ok) notes.push_back(exp);
    host_u.cyc(1'b1, tp, 8'h00, g);
    check(8'(g), 8'(ok));
  endtask

  // Reset with random straps in the given mode
  task automatic boot(input logic [1:0] m);
    @(negedge clk_i);
    reset_n_i = 1'b0;
    {port, qty, ads, en} = 4'($urandom);
    mode = m;
    ip = port ? cfg_pkg::IDX_PORT_SEC : cfg_pkg::IDX_PORT_PRI;
    tp = port ? cfg_pkg::TGT_PORT_SEC : cfg_pkg::TGT_PORT_PRI;
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    conclude();
  end

  initial begin
    void'($urandom(11));
    // Reset defaults in every configuration mode
    for (int m = 0; m < 4; m++) begin
      boot(2'(m));
      eq = (m == 2) ? qty : 1'b0;
      ea = m[1] ? ads : 1'b0;
      ee = m[1] ? en : 1'b1;
      check(8'(c_mode), 8'(m));
      check(8'({c_qty, c_ads, c_en}), 8'({eq, ea, ee}));
      rd(cfg_pkg::IDX_FDC_CFG, {eq, 5'h00, ea, ee}, 1'b1);
      rd(cfg_pkg::IDX_IRQ_MODE, 8'h00, 1'b1);
    end
    // DMA cycles and unmapped indexes leave everything untouched
    host_u.aen_o = 1'b1;
    wr(cfg_pkg::IDX_FDC_CFG, 8'h83);
    rd(cfg_pkg::IDX_FDC_CFG, 8'h00, 1'b0);
    host_u.aen_o = 1'b0;
    rd(8'h05, 8'h00, 1'b0);
    wr(8'h05, 8'hff);
    check(8'({c_qty, c_ads, c_en}), 8'({eq, ea, ee}));
    rd(cfg_pkg::IDX_IRQ_MODE, 8'h00, 1'b1);
    // Every count, address and enable combination with random styles
    for (int k = 0; k < 8; k++) begin
      v = 8'($urandom);
      {v[7], v[1], v[0]} = 3'(k);
      s = 8'($urandom);
      wr(cfg_pkg::IDX_FDC_CFG, v);
      wr(cfg_pkg::IDX_IRQ_MODE, s);
      rd(cfg_pkg::IDX_FDC_CFG, v & 8'h83, 1'b1);
      rd(cfg_pkg::IDX_IRQ_MODE, s & 8'hf8, 1'b1);
      check(8'({c_qty, c_ads, c_en}), 8'({v[7], v[1], v[0]}));
      @(negedge clk_i);
      {irq_req, irq_en, pd_i, dnum, drq, act} = 15'($urandom);
      if (!v[7]) dnum[1] = 1'b0;
      repeat (3) @(negedge clk_i);
      for (int l = 0; l < 5; l++) begin
        eo = s[l+3] ? 1'b0 : irq_req[l];
        en_n = !(irq_en[l] && (!s[l+3] || irq_req[l]));
        if (l == 3 && !v[0]) en_n = 1'b1;
        check(8'({irq_oe_n[l], irq_o[l] & !en_n}), 8'({en_n, eo & !en_n}));
      end
      check(8'({drq_oe_n, drq_o}), 8'({!v[0], drq}));
      check(8'({dsel_n, dec_en_n, pd_o}), v[7] ? 8'({dnum, !act, 1'b0}) :
            8'({act ? ~(2'b01 << dnum[0]) : 2'b11, 1'b1, pd_i}));
      cs_seen = 1'b0;
      host_u.cyc(1'b0, (v[7] ? 10'h370 : 10'h3f0) | 10'(k), 8'h00, g);
      check(8'(cs_seen), 8'((v[7] == v[1]) & v[0]));
    end
    check(8'(notes.size()), 8'h00);
    conclude();
  end
endmodule
